// File: design/cls_pkg.sv
/*
  Package for the configuration lock and device status register bank.
  Holds offsets, field positions, reset values, the unlock key and timing counts.
  Assumes a 32-bit software register port with word addresses given as byte addresses.
*/
package cls_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses.
  localparam logic [31:0] DEVICE_STATUS_OFFSET = 32'h01B3F004;
  localparam logic [31:0] CONFIG_LOCK_OFFSET   = 32'h01B3F018;
  localparam logic [31:0] PERIPH_CONFIG_OFFSET = 32'h01B3F000;

  localparam logic [31:0] UNLOCK_KEY          = 32'h10C0010C;
  localparam logic        LOCK_FLAG_RESET     = 1'h1;
  localparam int unsigned LOCK_FLAG_BIT       = 0;
  localparam logic [31:0] PERIPH_CONFIG_RESET = 32'h00000000;

  // Device status field positions.
  localparam int unsigned DS_NET_MAC_ENABLED_BIT    = 11;
  localparam int unsigned DS_HP_WIDTH_BIT  = 10;
  localparam int unsigned DS_EEAI_BIT      = 9;
  localparam int unsigned DS_PCI_EN_BIT    = 8;
  localparam int unsigned DS_CLK_MULT_LSB  = 5;
  localparam int unsigned DS_LITTLE_ENDIAN_FLAG_BIT   = 4;
  localparam int unsigned DS_BOOT_LSB      = 2;
  localparam int unsigned DS_EXT_CLK_LSB   = 0;

  // Latency of the configuration write path, and the settle time after enable.
  localparam int unsigned CFG_APPLY_CYCLES   = 2;
  localparam int unsigned ENABLE_WAIT_CYCLES = 128;

endpackage : cls_pkg

// File: design/cls_cfg_if.sv
/*
  Interface carrying a configuration write from the register front end to the apply stage.
  Assumes both ends share i_mclk.
*/
`timescale 1ns/10ps
interface cls_cfg_if;
  logic        wr_req;
  logic [31:0] wr_data;
  logic        busy;
  logic [31:0] cfg_value;

  modport front (output wr_req, output wr_data, input busy, input cfg_value);
  modport apply (input wr_req, input wr_data, output busy, output cfg_value);
endinterface : cls_cfg_if

// File: design/cls_cfg_apply.sv
/*
  Apply stage for the peripheral configuration register.
  A write travels through a short pipeline before it lands, as in a posted bus path.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module cls_cfg_apply
(
  input  wire logic i_mclk,    // Clock.
  input  wire logic i_reset_n, // Synchronous reset, active low.
  cls_cfg_if.apply  cfg        // Write request in, stored value out.
);

  logic [31:0] data_q;
  logic [1:0]  cnt_q;
  logic        pend_q;
  logic [31:0] cfg_q;

  localparam logic [1:0] APPLY_LAST = 2'(cls_pkg::CFG_APPLY_CYCLES - 1);

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      pend_q <= 1'b0;
      cnt_q  <= 2'h0;
      data_q <= 32'h00000000;
    end
    else if (cfg.wr_req)
    begin
      pend_q <= 1'b1;
      cnt_q  <= 2'h0;
      data_q <= cfg.wr_data;
    end
    else if (pend_q)
    begin
      if (cnt_q == APPLY_LAST)
        pend_q <= 1'b0;
      cnt_q <= cnt_q + 2'h1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      cfg_q <= cls_pkg::PERIPH_CONFIG_RESET;
    else if (pend_q && cnt_q == APPLY_LAST)
      cfg_q <= data_q;
  end

  assign cfg.busy      = pend_q || cfg.wr_req;
  assign cfg.cfg_value = cfg_q;

endmodule : cls_cfg_apply

// File: design/cls_lock_status.sv
/*
  Configuration lock, peripheral configuration register and device status register.
  Assumes a simple software port: one-cycle strobes, read data one cycle after the read strobe unless a configuration read is held,
  and configuration straps that are stable while reset is held and at its release.
*/
// The strobed register port was decided locally.
// Summary of operation
// [R1] Lock flag reads in bit 0 of the lock register; set out of reset.
// [R2] Configuration writes are dropped while the lock flag is set.
// [R3] Configuration register reads back regardless of the lock flag.
// [R4] Writing the full 32-bit unlock key to the lock register clears the flag.
// [R5] Lock register bits 31:1 read zero; writes to them change nothing.
// [R6] Every configuration write sets the lock flag again.
// [R7] Software should set all enables in one configuration write.
// [R8] A configuration read after a write waits until the write has landed.
// [R9] Masters wait 128 cycles after an enable before using that peripheral.
// [R10] Masters never access a peripheral whose enable is clear.
// [R11] Status bit 11 shows network MAC enable; no effect when PCI enabled.
// [R12] Status bit 10 shows host port width: 0 16-bit, 1 32-bit.
// [R13] Status bit 9 shows PCI EEPROM auto-initialisation.
// [R14] Status bit 8 shows PCI enable.
// [R15] Status bits 6:5 show the CPU clock multiplier.
// [R16] Status bit 4 shows byte order, 1 little-endian.
// [R17] Status bits 3:2 show the boot mode.
// [R18] Status bits 1:0 show the external memory clock source.
// [R19] Peripheral enables change only while the lock flag is clear. An accepted write lands two cycles later, after it has set the flag again.
// [R20] Status register is read-only; bits 31:12 and 7 read zero.
`timescale 1ns/10ps
module cls_lock_status
(
  input  wire logic        i_mclk,             // Clock, 100 MHz.
  input  wire logic        i_reset_n,          // Synchronous reset, active low.
  input  wire logic [31:0] i_addr,             // Register byte address.
  input  wire logic [31:0] i_wdata,            // Write data.
  input  wire logic        i_wr,               // Write strobe.
  input  wire logic        i_rd,               // Read strobe.
  output logic      [31:0] o_rdata,            // Read data, one cycle after i_rd; later for a held configuration read.
  output logic             o_rvalid,           // Read data valid.
  input  wire logic        i_net_mac_enabled,  // Strap: network MAC enable.
  input  wire logic        i_host_port_width,  // Strap: host port width.
  input  wire logic        i_pci_eeprom_autoinit, // Strap: PCI EEPROM init.
  input  wire logic        i_pci_enable,       // Strap: PCI enable.
  input  wire logic [1:0]  i_cpu_clock_multiplier, // Strap: CPU clock multiplier.
  input  wire logic        i_little_endian_flag, // Strap: byte order.
  input  wire logic [1:0]  i_boot_mode,        // Strap: boot mode.
  input  wire logic [1:0]  i_ext_mem_clock_source, // Strap: memory clock source.
  output logic      [31:0] o_peripheral_config, // Applied configuration value.
  output logic             o_lock_flag         // Current lock flag.
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Decode.

  cls_cfg_if cfg_bus ();

  // A read is either answered at once or parked until a configuration write has landed.
  typedef enum logic {
    RD_IDLE,
    RD_HELD
  } cls_rd_state_t;

  cls_rd_state_t rd_state_q;
  logic          lock_flag_q;
  logic          in_reset_q;
  logic [11:0]   status_q;
  logic          rvalid_q;
  logic [31:0]   rdata_q;
  logic [31:0]   read_mux;
  logic          hit_lock;
  logic          hit_cfg;
  logic          hit_stat;
  logic          cfg_write;
  logic          key_write;
  logic          held_done;
  logic          read_now;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Whole-word compare: partial decoding would alias the lock onto other addresses.
  function automatic logic addr_hit
  (
    input logic [31:0] addr,   // Address on the port.
    input logic [31:0] offset  // Register byte address.
  );
    addr_hit = (addr == offset);
  endfunction : addr_hit

  // The key is matched on all 32 bits, so a near miss never unlocks the register.
  function automatic logic key_match
  (
    input logic [31:0] data    // Write data on the port.
  );
    key_match = (data == cls_pkg::UNLOCK_KEY);
  endfunction : key_match

  // Lock register read word: only the flag bit is live.
  function automatic logic [31:0] lock_word
  (
    input logic flag           // Current lock flag.
  );
    logic [31:0] word;
    word                         = 32'h00000000; // [R5]
    word[cls_pkg::LOCK_FLAG_BIT] = flag;         // [R1]
    lock_word                    = word;
  endfunction : lock_word

  // Places each strap at its status position; bit 7 and bits 31:12 are never driven.
  function automatic logic [11:0] pack_status
  (
    input logic       mac,     // Network MAC enable.
    input logic       width,   // Host port width.
    input logic       eeai,    // PCI EEPROM auto-initialisation.
    input logic       pci,     // PCI enable.
    input logic [1:0] mult,    // CPU clock multiplier.
    input logic       lend,    // Byte order.
    input logic [1:0] boot,    // Boot mode.
    input logic [1:0] clk_src  // External memory clock source.
  );
    logic [11:0] word;
    word                                = 12'h000; // [R20]
    word[cls_pkg::DS_NET_MAC_ENABLED_BIT]        = mac;     // [R11]
    word[cls_pkg::DS_HP_WIDTH_BIT]      = width;   // [R12]
    word[cls_pkg::DS_EEAI_BIT]          = eeai;    // [R13]
    word[cls_pkg::DS_PCI_EN_BIT]        = pci;     // [R14]
    word[cls_pkg::DS_CLK_MULT_LSB +: 2] = mult;    // [R15]
    word[cls_pkg::DS_LITTLE_ENDIAN_FLAG_BIT]       = lend;    // [R16]
    word[cls_pkg::DS_BOOT_LSB +: 2]     = boot;    // [R17]
    word[cls_pkg::DS_EXT_CLK_LSB +: 2]  = clk_src; // [R18]
    pack_status                         = word;
  endfunction : pack_status

  assign hit_lock  = addr_hit(i_addr, cls_pkg::CONFIG_LOCK_OFFSET);
  assign hit_cfg   = addr_hit(i_addr, cls_pkg::PERIPH_CONFIG_OFFSET);
  assign hit_stat  = addr_hit(i_addr, cls_pkg::DEVICE_STATUS_OFFSET);
  assign key_write = i_wr && hit_lock && key_match(i_wdata); // [R4]

  // Locked writes never reach the apply stage.
  assign cfg_write       = i_wr && hit_cfg && !lock_flag_q; // [R2] [R19]
  assign cfg_bus.wr_req  = cfg_write;
  assign cfg_bus.wr_data = i_wdata;

  cls_cfg_apply u_apply
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .cfg       (cfg_bus.apply)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Lock flag.

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      lock_flag_q <= cls_pkg::LOCK_FLAG_RESET; // [R1]
    else if (i_wr && hit_cfg)
      lock_flag_q <= 1'b1; // [R6]
    else if (key_write)
      lock_flag_q <= 1'b0; // [R4] [R5]
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Strap capture: taken on the first clock after reset releases, never under reset itself.

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      in_reset_q <= 1'b1;
    else
      in_reset_q <= 1'b0;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      status_q <= 12'h000;
    else if (in_reset_q)
      status_q <= pack_status(i_net_mac_enabled, i_host_port_width, i_pci_eeprom_autoinit,
                              i_pci_enable, i_cpu_clock_multiplier, i_little_endian_flag,
                              i_boot_mode, i_ext_mem_clock_source); // [R20]
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Read path. A configuration read that meets a pending write is held back until the write
  // lands, then answered; strobes arriving meanwhile are not expected from the master.

  assign held_done = (rd_state_q == RD_HELD) && !cfg_bus.busy; // [R8]
  assign read_now  = i_rd && !(hit_cfg && cfg_bus.busy);

  // Unmapped addresses read as zero rather than floating old data.
  always_comb
  begin
    read_mux = 32'h00000000;
    if (hit_lock)
      read_mux = lock_word(lock_flag_q); // [R1] [R5]
    else if (hit_cfg)
      read_mux = cfg_bus.cfg_value; // [R3]
    else if (hit_stat)
      read_mux = {20'h00000, status_q}; // [R20]
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      rd_state_q <= RD_IDLE;
    else
    begin
      unique case (rd_state_q)
        RD_IDLE:
          if (i_rd && hit_cfg && cfg_bus.busy)
            rd_state_q <= RD_HELD; // [R8]
        RD_HELD:
          if (!cfg_bus.busy)
            rd_state_q <= RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      rvalid_q <= 1'b0;
    else
      rvalid_q <= held_done || read_now;
  end

  // The held answer takes priority; the master issues nothing else while a read is held.
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      rdata_q <= 32'h00000000;
    else if (held_done)
      rdata_q <= cfg_bus.cfg_value; // [R8]
    else if (read_now)
      rdata_q <= read_mux;
    else
      rdata_q <= 32'h00000000;
  end

  assign o_rdata             = rdata_q;
  assign o_rvalid            = rvalid_q;
  assign o_peripheral_config = cfg_bus.cfg_value;
  assign o_lock_flag         = lock_flag_q;

endmodule : cls_lock_status

// File: tb/cls_lock_status_monitor.sv
/*
  Checker for the lock and status bank, on the top ports only.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module cls_lock_status_monitor
(
  input wire logic        i_mclk,              // Clock.
  input wire logic        i_reset_n,           // Reset.
  input wire logic [31:0] i_addr,              // Address.
  input wire logic [31:0] i_wdata,             // Write data.
  input wire logic        i_wr,                // Write strobe.
  input wire logic        i_rd,                // Read strobe.
  input wire logic [31:0] o_rdata,             // Read data.
  input wire logic        o_rvalid,            // Read valid.
  input wire logic [31:0] o_peripheral_config, // Applied value.
  input wire logic        o_lock_flag          // Lock flag.
);
  localparam logic [31:0] LK  = cls_pkg::CONFIG_LOCK_OFFSET;
  localparam logic [31:0] PC  = cls_pkg::PERIPH_CONFIG_OFFSET;
  localparam logic [31:0] DS  = cls_pkg::DEVICE_STATUS_OFFSET;
  localparam logic [31:0] KEY = cls_pkg::UNLOCK_KEY;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////
  chk_rd_fast: assert property (i_rd && i_addr != PC |=> o_rvalid)
    else $error("read not answered");
  chk_rd_stall: assert property (i_rd && i_addr == PC |-> ##[1:3] o_rvalid)
    else $error("config read held too long");
  chk_lock_read: assert property
    (i_rd && i_addr == LK |=> o_rdata == {31'h0, $past(o_lock_flag)})
    else $error("lock read wrong");
  chk_key_unlock: assert property
    (i_wr && i_addr == LK && i_wdata == KEY |=> !o_lock_flag)
    else $error("key did not unlock");
  chk_bad_key: assert property
    (i_wr && i_addr == LK && i_wdata != KEY && o_lock_flag |=> o_lock_flag)
    else $error("wrong key unlocked");
  chk_cfg_relock: assert property (i_wr && i_addr == PC |=> o_lock_flag)
    else $error("config write did not relock");
  // The value lands on the second edge after the strobe and is sampled on the third.
  chk_cfg_land: assert property
    (i_wr && i_addr == PC && !o_lock_flag |-> ##3 o_peripheral_config == $past(i_wdata, 3))
    else $error("config write did not land");
  chk_locked_drop: assert property
    (i_wr && i_addr == PC && o_lock_flag |-> ##3 $stable(o_peripheral_config))
    else $error("locked write changed config");
  chk_status_rsvd: assert property
    (i_rd && i_addr == DS |=> o_rdata[31:12] == 20'h0 && !o_rdata[7])
    else $error("status reserved bits set");
  cover property (i_wr && i_addr == LK && i_wdata == KEY);
  cover property (i_wr && i_addr == PC && !o_lock_flag);
  cover property (i_rd && i_addr == DS);
  cover property (i_rd && i_addr == PC ##1 !o_rvalid);
endmodule : cls_lock_status_monitor
bind cls_lock_status cls_lock_status_monitor u_mon (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_rvalid(o_rvalid), .o_peripheral_config(o_peripheral_config), .o_lock_flag(o_lock_flag));

// File: tb/cls_lock_status_tb.sv
/*
  Self-checking bench for the lock and status bank.
  Assumes the bound checker and the register port timing of the design.
*/
`timescale 1ns/10ps
module cls_lock_status_tb;
  localparam logic [31:0] LK  = cls_pkg::CONFIG_LOCK_OFFSET;
  localparam logic [31:0] PC  = cls_pkg::PERIPH_CONFIG_OFFSET;
  localparam logic [31:0] DS  = cls_pkg::DEVICE_STATUS_OFFSET;
  localparam logic [31:0] KEY = cls_pkg::UNLOCK_KEY;
  logic        i_mclk, o_rvalid, o_lock_flag;
  logic        i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [31:0] i_addr = 32'h0, i_wdata = 32'h0, o_rdata, o_peripheral_config;
  logic [10:0] s = 11'h000;
  int          fails = 0, comparisons = 0;
  // Each row: straps, then the status word they should produce.
  logic [42:0] rows [4] = '{{11'h000, 32'h00000000}, {11'h7FF, 32'h00000F7F},
                            {11'h535, 32'h00000A35}, {11'h2CA, 32'h0000054A}};
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  cls_lock_status DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_net_mac_enabled(s[10]), .i_host_port_width(s[9]), .i_pci_eeprom_autoinit(s[8]),
    .i_pci_enable(s[7]), .i_cpu_clock_multiplier(s[6:5]), .i_little_endian_flag(s[4]),
    .i_boot_mode(s[3:2]), .i_ext_mem_clock_source(s[1:0]),
    .o_peripheral_config(o_peripheral_config), .o_lock_flag(o_lock_flag));
  ////////////////////////////////////////
  task automatic complete_run;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic bus(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
  endtask : bus
  // A held config read may take several cycles, so the wait is bounded, not fixed.
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    bus(1'b0, 1'b1, a, 32'h0);
    i_rd <= 1'b0;
    do
    begin
      @(negedge i_mclk);
      n++;
    end
    while (o_rvalid !== 1'b1 && n < 4);
    comparisons++;
    if (o_rvalid !== 1'b1 || o_rdata !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, o_rdata, exp);
      if (o_rvalid !== 1'b1)
        complete_run();
    end
    @(posedge i_mclk);
  endtask : rd
  task automatic peek_cfg(input logic [31:0] exp);
    @(negedge i_mclk);
    comparisons++;
    if (o_peripheral_config !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, o_peripheral_config, exp);
    end
    @(posedge i_mclk);
  endtask : peek_cfg
  task automatic reset_dut;
    i_reset_n <= 1'b0;
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (4) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
  endtask : reset_dut
  ////////////////////////////////////////
  initial
  begin
    for (int k = 0; k < 4; k++)
    begin
      s <= rows[k][42:32];
      reset_dut();
      s <= ~rows[k][42:32];
      rd(DS, rows[k][31:0]);
      $display("status row %0d done", k);
    end
    reset_dut();
    rd(LK, 32'h00000001);
    bus(1'b1, 1'b0, PC, 32'hA5A55A5A);
    rd(PC, 32'h00000000);
    bus(1'b1, 1'b0, LK, KEY ^ 32'h00000001);
    bus(1'b1, 1'b0, LK, 32'hFFFFFFFE);
    rd(LK, 32'h00000001);
    $display("locked cases done");
    bus(1'b1, 1'b0, LK, KEY);
    rd(LK, 32'h00000000);
    rd(PC, 32'h00000000);
    // All enables go in one write, since every configuration write relocks.
    bus(1'b1, 1'b0, PC, 32'h0000F00D);
    rd(PC, 32'h0000F00D);
    peek_cfg(32'h0000F00D);
    // Settle time after an enable; no enabled or disabled peripheral is touched meanwhile.
    repeat (cls_pkg::ENABLE_WAIT_CYCLES) @(posedge i_mclk);
    rd(LK, 32'h00000001);
    bus(1'b1, 1'b0, PC, 32'h12345678);
    rd(PC, 32'h0000F00D);
    bus(1'b1, 1'b0, DS, 32'hFFFFFFFF);
    rd(DS, 32'h00000A35);
    rd(32'h01B3F010, 32'h00000000);
    $display("unlocked cases done");
    bus(1'b1, 1'b0, LK, KEY);
    reset_dut();
    rd(LK, 32'h00000001);
    rd(PC, 32'h00000000);
    $display("reset cases done");
    complete_run();
  end
endmodule : cls_lock_status_tb
